// ===== rtl/swt_pkg.sv
// swt_pkg: constants, register map and carrier types for the sleep wake countdown timers
package swt_pkg;

	localparam int SWT_NUM = 2;
	localparam int SWT_CNT_W = 32;
	localparam int SWT_ADDR_W = 8;
	localparam logic [SWT_CNT_W-1:0] SWT_RELOAD = 32'hffffffff;
	localparam logic [SWT_CNT_W-1:0] SWT_CAL_PERIODS = 32'h00000014;
	localparam logic [SWT_CNT_W-1:0] SWT_TICKS_PER_MS = 32'h00000020;

	// register byte offsets
	localparam logic [SWT_ADDR_W-1:0] SWT_CTRL = 8'h00;
	localparam logic [SWT_ADDR_W-1:0] SWT_IRQ_EN = 8'h04;
	localparam logic [SWT_ADDR_W-1:0] SWT_LOAD0 = 8'h08;
	localparam logic [SWT_ADDR_W-1:0] SWT_LOAD1 = 8'h0c;
	localparam logic [SWT_ADDR_W-1:0] SWT_COUNT0 = 8'h10;
	localparam logic [SWT_ADDR_W-1:0] SWT_COUNT1 = 8'h14;
	localparam logic [SWT_ADDR_W-1:0] SWT_RUNNING = 8'h18;
	localparam logic [SWT_ADDR_W-1:0] SWT_FIRED = 8'h1c;
	localparam logic [SWT_ADDR_W-1:0] SWT_INT_STAT = 8'h20;
	localparam logic [SWT_ADDR_W-1:0] SWT_INT_MASK = 8'h24;
	localparam logic [SWT_ADDR_W-1:0] SWT_CAL_RESULT = 8'h28;
	localparam logic [SWT_ADDR_W-1:0] SWT_CAL_STAT = 8'h2c;

	// control register field positions (write-one pulses)
	localparam int SWT_CTRL_START = 0;
	localparam int SWT_CTRL_STOP = 2;
	localparam int SWT_CTRL_CAL = 4;

	// interrupt status field positions
	localparam int SWT_INT_FIRE = 0;
	localparam int SWT_INT_CAL = 2;
	localparam int SWT_INT_W = 3;

	// reset values
	localparam logic [SWT_INT_W-1:0] SWT_INT_RST = 3'h0;
	localparam logic [SWT_NUM-1:0] SWT_BITS_RST = 2'h0;
	localparam logic [SWT_CNT_W-1:0] SWT_WORD_RST = 32'h00000000;

	typedef struct packed {
		logic start;
		logic stop;
		logic cal_load;
		logic [SWT_CNT_W-1:0] load;
	} swt_cmd_type;

	typedef struct packed {
		logic running;
		logic zero;
		logic [SWT_CNT_W-1:0] count;
	} swt_stat_type;

endpackage

// ===== rtl/swt_timer.sv
// swt_timer: one wake down-counter stepped by the slow clock tick
`timescale 1ns/1ps
module swt_timer
	import swt_pkg::*;
(
	input wire logic clk_in, // system clock
	input wire logic rstn_in, // async reset, active low
	input wire logic tick_in, // one slow-clock period elapsed
	input wire swt_cmd_type cmd_in, // start, stop, calibration load
	output swt_stat_type stat_out // count, running, zero-reached pulse
);

	typedef enum logic [1:0] {
		SWT_IDLE = 2'b01,
		SWT_RUN = 2'b10
	} swt_state_type;

	swt_state_type state_r, state_nxt;
	logic [SWT_CNT_W-1:0] count_r, count_nxt;
	logic zero_r, zero_nxt;

	always_comb begin
		state_nxt = state_r;
		count_nxt = count_r;
		zero_nxt = 1'b0;
		case (state_r)
			SWT_IDLE: begin
				// stopped: count frozen, no events
			end
			SWT_RUN: begin
				if (cmd_in.stop) begin
					state_nxt = SWT_IDLE;
				end else if (tick_in) begin
					if (count_r == SWT_WORD_RST) begin
						count_nxt = SWT_RELOAD;
					end else begin
						count_nxt = count_r - 32'h00000001;
						zero_nxt = (count_nxt == SWT_WORD_RST);
					end
				end
			end
			default: begin
				state_nxt = SWT_IDLE;
			end
		endcase
		// a load takes priority over stop and tick
		if (cmd_in.cal_load) begin
			count_nxt = SWT_CAL_PERIODS;
			state_nxt = SWT_RUN;
			zero_nxt = 1'b0;
		end else if (cmd_in.start) begin
			count_nxt = cmd_in.load;
			state_nxt = SWT_RUN;
			zero_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_r <= SWT_IDLE;
			count_r <= SWT_WORD_RST;
			zero_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			count_r <= count_nxt;
			zero_r <= zero_nxt;
		end
	end

	assign stat_out.running = (state_r == SWT_RUN);
	assign stat_out.zero = zero_r;
	assign stat_out.count = count_r;

endmodule

// ===== rtl/swt_top.sv
// swt_top: two sleep wake countdown timers with calibration and register port
//
// Summary of operation
// - two wake timers, 32-bit counters here
// - counters step on slow clock while started, idle from reset
// - decrement per tick, wake event at zero
// - per-timer interrupt enable gates zero interrupt
// - start value counted in slow-clock periods
// - at zero set fired, reload ones, continue
// - interrupt rises one cycle after the zero count
// - stop freezes count, no further events
// - count read leaves countdown undisturbed
// - running status bit per timer
// - fired bit per timer, cleared by read
// - fired bits survive wake from sleep
// - calibration loads 20, clears reference counter
// - result is reference count at zero
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module swt_top
	import swt_pkg::*;
(
	input wire logic clk_in, // system clock, also calibration reference
	input wire logic rstn_in, // async reset, active low
	input wire logic slow_tick_in, // one-cycle pulse per slow-clock period
	input wire logic [SWT_ADDR_W-1:0] addr_in, // register byte address
	input wire logic [31:0] wdata_in, // write data
	input wire logic wr_in, // write strobe
	input wire logic rd_in, // read strobe
	output logic [31:0] rdata_out, // read data, cycle after rd_in
	output logic irq_out, // level interrupt
	output logic [SWT_NUM-1:0] wake_out // wake-up event pulse per timer
);

	swt_cmd_type cmd [SWT_NUM];
	swt_stat_type stat [SWT_NUM];

	logic [SWT_NUM-1:0] irq_en_r, irq_en_nxt;
	logic [SWT_CNT_W-1:0] load_r [SWT_NUM];
	logic [SWT_CNT_W-1:0] load_nxt [SWT_NUM];
	logic [SWT_NUM-1:0] fired_r, fired_nxt;
	logic [SWT_INT_W-1:0] int_stat_r, int_stat_nxt;
	logic [SWT_INT_W-1:0] int_mask_r, int_mask_nxt;
	logic [SWT_INT_W-1:0] int_set;
	logic [SWT_CNT_W-1:0] ref_r, ref_nxt;
	logic [SWT_CNT_W-1:0] cal_res_r, cal_res_nxt;
	logic cal_busy_r, cal_busy_nxt;
	logic cal_done_r, cal_done_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic irq_r, irq_nxt;
	logic [SWT_NUM-1:0] wake_r, wake_nxt;
	logic [SWT_NUM-1:0] zero_evt;
	logic [SWT_NUM-1:0] run_bits;
	logic wr_ctrl;
	logic cal_start;
	logic cal_end;

	assign wr_ctrl = wr_in && (addr_in == SWT_CTRL);
	assign cal_start = wr_ctrl && wdata_in[SWT_CTRL_CAL];
	// calibration ends on the same zero pulse that would raise timer 0's event
	assign cal_end = cal_busy_r && zero_evt[0];

	genvar g;
	generate
		for (g = 0; g < SWT_NUM; g++) begin : gen_tmr
			always_comb begin
				cmd[g].start = wr_ctrl && wdata_in[SWT_CTRL_START + g];
				cmd[g].stop = wr_ctrl && wdata_in[SWT_CTRL_STOP + g];
				cmd[g].cal_load = (g == 0) && cal_start;
				cmd[g].load = load_r[g];
			end

			swt_timer u_timer (
				.clk_in(clk_in),
				.rstn_in(rstn_in),
				.tick_in(slow_tick_in),
				.cmd_in(cmd[g]),
				.stat_out(stat[g])
			);

			assign zero_evt[g] = stat[g].zero;
			assign run_bits[g] = stat[g].running;
		end
	endgenerate

	// register file and calibration
	always_comb begin
		irq_en_nxt = irq_en_r;
		int_mask_nxt = int_mask_r;
		fired_nxt = fired_r;
		int_stat_nxt = int_stat_r;
		ref_nxt = ref_r;
		cal_res_nxt = cal_res_r;
		cal_busy_nxt = cal_busy_r;
		cal_done_nxt = cal_done_r;
		for (int i = 0; i < SWT_NUM; i++) begin
			load_nxt[i] = load_r[i];
		end
		rdata_nxt = 32'h00000000;

		if (wr_in) begin
			case (addr_in)
				SWT_IRQ_EN: irq_en_nxt = wdata_in[SWT_NUM-1:0];
				SWT_LOAD0: load_nxt[0] = wdata_in[SWT_CNT_W-1:0];
				SWT_LOAD1: load_nxt[1] = wdata_in[SWT_CNT_W-1:0];
				SWT_INT_STAT: int_stat_nxt = int_stat_r & ~wdata_in[SWT_INT_W-1:0];
				SWT_INT_MASK: int_mask_nxt = wdata_in[SWT_INT_W-1:0];
				default: begin
				end
			endcase
		end

		if (rd_in) begin
			case (addr_in)
				SWT_CTRL: rdata_nxt = 32'h00000000;
				SWT_IRQ_EN: rdata_nxt = {30'h00000000, irq_en_r};
				SWT_LOAD0: rdata_nxt = load_r[0];
				SWT_LOAD1: rdata_nxt = load_r[1];
				SWT_COUNT0: rdata_nxt = stat[0].count;
				SWT_COUNT1: rdata_nxt = stat[1].count;
				SWT_RUNNING: rdata_nxt = {30'h00000000, run_bits};
				SWT_FIRED: begin
					rdata_nxt = {30'h00000000, fired_r};
					fired_nxt = SWT_BITS_RST;
				end
				SWT_INT_STAT: rdata_nxt = {29'h00000000, int_stat_r};
				SWT_INT_MASK: rdata_nxt = {29'h00000000, int_mask_r};
				SWT_CAL_RESULT: rdata_nxt = cal_res_r;
				SWT_CAL_STAT: rdata_nxt = {30'h00000000, cal_busy_r, cal_done_r};
				default: rdata_nxt = 32'h00000000;
			endcase
		end

		// hardware set beats a read-clear landing in the same cycle
		fired_nxt = fired_nxt | zero_evt;
		int_set = SWT_INT_RST;
		int_set[SWT_INT_FIRE +: SWT_NUM] = zero_evt & irq_en_r;
		int_set[SWT_INT_CAL] = cal_end;
		int_stat_nxt = int_stat_nxt | int_set;

		if (cal_start) begin
			ref_nxt = SWT_WORD_RST;
			cal_busy_nxt = 1'b1;
			cal_done_nxt = 1'b0;
		end else if (cal_end) begin
			// ref_r already counts every edge from the start up to the zero edge
			cal_res_nxt = ref_r;
			cal_busy_nxt = 1'b0;
			cal_done_nxt = 1'b1;
		end else if (cal_busy_r) begin
			ref_nxt = ref_r + 32'h00000001;
		end
		// a stop of timer 0 abandons the measurement rather than leave it busy forever
		if (cal_busy_r && cmd[0].stop && !cal_start) begin
			cal_busy_nxt = 1'b0;
		end

		// interrupt follows the status that the zero pulse sets this edge
		irq_nxt = |(int_stat_nxt & int_mask_r);
		wake_nxt = zero_evt;
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_en_r <= SWT_BITS_RST;
			int_mask_r <= SWT_INT_RST;
			fired_r <= SWT_BITS_RST;
			int_stat_r <= SWT_INT_RST;
			ref_r <= SWT_WORD_RST;
			cal_res_r <= SWT_WORD_RST;
			cal_busy_r <= 1'b0;
			cal_done_r <= 1'b0;
			for (int i = 0; i < SWT_NUM; i++) begin
				load_r[i] <= SWT_WORD_RST;
			end
			rdata_r <= 32'h00000000;
			irq_r <= 1'b0;
			wake_r <= SWT_BITS_RST;
		end else begin
			irq_en_r <= irq_en_nxt;
			int_mask_r <= int_mask_nxt;
			fired_r <= fired_nxt;
			int_stat_r <= int_stat_nxt;
			ref_r <= ref_nxt;
			cal_res_r <= cal_res_nxt;
			cal_busy_r <= cal_busy_nxt;
			cal_done_r <= cal_done_nxt;
			for (int i = 0; i < SWT_NUM; i++) begin
				load_r[i] <= load_nxt[i];
			end
			rdata_r <= rdata_nxt;
			irq_r <= irq_nxt;
			wake_r <= wake_nxt;
		end
	end

	assign rdata_out = rdata_r;
	assign irq_out = irq_r;
	assign wake_out = wake_r;

endmodule

// ===== test/swt_properties.sv
// swt_properties: port assertions for the wake timer block
`timescale 1ns/1ps
module swt_properties
	import swt_pkg::*;
(
	input wire logic clk_in, // clock
	input wire logic rstn_in, // reset, low
	input wire logic slow_tick_in, // tick
	input wire logic [SWT_ADDR_W-1:0] addr_in, // address
	input wire logic [31:0] wdata_in, // write data
	input wire logic wr_in, // write
	input wire logic rd_in, // read
	input wire logic [31:0] rdata_out, // read data
	input wire logic irq_out, // interrupt
	input wire logic [SWT_NUM-1:0] wake_out // wake pulses
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	logic rf, rc, clr;
	assign rf = rd_in && addr_in == SWT_FIRED;
	assign rc = rd_in && addr_in == SWT_COUNT0;
	assign clr = wr_in && addr_in == SWT_INT_STAT && wdata_in[2:0] == 3'h7;
	AST_RD_IDLE: assert property (!rd_in |=> rdata_out == 32'h0)
		else $error("read data not idle");
	AST_WAKE_CAUSE: assert property (|wake_out |-> $past(slow_tick_in, 2))
		else $error("wake without tick");
	AST_WAKE_PULSE: assert property (wake_out[0] |=> !wake_out[0])
		else $error("wake pulse too long");
	AST_FIRED_CLR: assert property (rf && !$past(slow_tick_in) ##1 rf |=> rdata_out[1:0] == 2'h0)
		else $error("fired not cleared by read");
	AST_IRQ_CLR: assert property (clr && !$past(slow_tick_in) |=> !irq_out)
		else $error("interrupt stays after clear");
	AST_IRQ_RISE: assert property ($rose(irq_out) |-> $past(slow_tick_in, 2) || $past(wr_in, 2)
		|| $past(wr_in)) else $error("interrupt without cause");
	AST_COUNT_STABLE: assert property (rc && !slow_tick_in ##1 rc |=> rdata_out == $past(rdata_out))
		else $error("count read disturbed");
	AST_RUN_BITS: assert property (rd_in && addr_in == SWT_RUNNING |=> rdata_out[31:2] == 30'h0)
		else $error("running bits");
	cover property (wake_out[0]);
	cover property ($rose(irq_out));
	cover property (rf ##1 rf);
endmodule
bind swt_top swt_properties u_chk (.clk_in(clk_in), .rstn_in(rstn_in),
	.slow_tick_in(slow_tick_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
	.rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out), .wake_out(wake_out));

// ===== test/test_sleep_wake_countdown_timer.sv
// test_sleep_wake_countdown_timer: model bench for the wake timers
`timescale 1ns/1ps
module test_sleep_wake_countdown_timer
	import swt_pkg::*;
;
	logic clk_in = 1'h0, rstn_in = 1'h0, slow_tick_in = 1'h0, wr_in = 1'h0, rd_in = 1'h0;
	logic [7:0] addr_in = 8'h0;
	logic [31:0] wdata_in = 32'h0, rdata_out;
	logic irq_out;
	logic [1:0] wake_out, run = 2'h0, en = 2'h0;
	logic [2:0] st = 3'h0;
	int unsigned cnt[2], seed = 20995, res;
	int num_errors = 0, n_compared = 0;
	int wk_exp = 0, wk_seen = 0;
	bit cal = 0;
	time t0, tz;
	swt_top DUT (.clk_in(clk_in), .rstn_in(rstn_in), .slow_tick_in(slow_tick_in),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .irq_out(irq_out), .wake_out(wake_out));
	always #50 clk_in = ~clk_in;
	// wake pulses are one cycle wide, so sampling mid-cycle counts each once
	always @(negedge clk_in) wk_seen += wake_out[0] + wake_out[1];
	function automatic int unsigned rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic results();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask
	// callers sit just after an edge, so strobes stay one cycle wide
	task automatic wrt(input logic [7:0] a, input logic [31:0] d);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'h1;
		@(posedge clk_in);
		wr_in <= 1'h0;
		#1;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		addr_in <= a;
		rd_in <= 1'h1;
		@(posedge clk_in);
		rd_in <= 1'h0;
		#1 chk($sformatf("reg %h", a), e, rdata_out);
	endtask
	task automatic tick();
		tz = $time;
		slow_tick_in <= 1'h1;
		@(posedge clk_in);
		slow_tick_in <= 1'h0;
		#1;
		for (int i = 0; i < 2; i++) begin
			if (run[i] && cnt[i] == 0) begin
				cnt[i] = 32'hffffffff;
			end else if (run[i] && --cnt[i] == 0) begin
				st[i] |= en[i];
				wk_exp++;
				if (cal && i == 0) begin
					st[2] = 1'h1;
					cal = 0;
					res = (tz - t0) / 100;
				end
			end
		end
	endtask
	initial begin
		#1000000;
		num_errors++;
		results();
	end
	initial begin
		repeat (8) @(posedge clk_in);
		rstn_in <= 1'h1;
		@(posedge clk_in);
		#1;
		for (int a = 0; a <= 48; a += 4) rdc(a[7:0], 32'h0);
		cnt[0] = 2 + rnd() % 6;
		cnt[1] = cnt[0] + 3 + rnd() % 4;
		wrt(SWT_IRQ_EN, 32'h3);
		wrt(SWT_INT_MASK, 32'h7);
		wrt(SWT_LOAD0, cnt[0]);
		wrt(SWT_LOAD1, cnt[1]);
		wrt(SWT_CTRL, 32'h3);
		en = 2'h3;
		run = 2'h3;
		rdc(SWT_RUNNING, 32'h3);
		repeat (cnt[0] + 2) begin
			tick();
			rdc(SWT_COUNT0, cnt[0]);
			rdc(SWT_COUNT0, cnt[0]);
			rdc(SWT_COUNT1, cnt[1]);
		end
		chk("irq", 32'h1, {31'h0, irq_out});
		rdc(SWT_FIRED, 32'h1);
		rdc(SWT_FIRED, 32'h0);
		wrt(SWT_CTRL, 32'h8);
		run[1] = 1'h0;
		repeat (3) tick();
		rdc(SWT_COUNT1, cnt[1]);
		rdc(SWT_RUNNING, 32'h1);
		wrt(SWT_INT_STAT, 32'h7);
		st = 3'h0;
		repeat (2) @(posedge clk_in);
		#1 chk("irq", 32'h0, {31'h0, irq_out});
		wrt(SWT_IRQ_EN, 32'h2);
		en = 2'h2;
		wrt(SWT_LOAD0, 32'h1);
		wrt(SWT_CTRL, 32'h1);
		cnt[0] = 1;
		tick();
		rdc(SWT_INT_STAT, 32'h0);
		rdc(SWT_FIRED, 32'h1);
		wrt(SWT_CTRL, 32'h4);
		run[0] = 1'h0;
		rdc(SWT_FIRED, 32'h0);
		t0 = $time;
		wrt(SWT_CTRL, 32'h10);
		cnt[0] = 20;
		run[0] = 1'h1;
		cal = 1;
		rdc(SWT_COUNT0, 32'h14);
		repeat (20) begin
			repeat (rnd() % 3) @(posedge clk_in);
			#1 tick();
		end
		// the result lands one cycle after the zero count
		@(posedge clk_in);
		#1 rdc(SWT_CAL_RESULT, res);
		rdc(SWT_CAL_STAT, 32'h1);
		rdc(SWT_INT_STAT, {29'h0, st});
		repeat (5) tick();
		rdc(SWT_CAL_RESULT, res);
		chk("wake count", wk_exp, wk_seen);
		results();
	end
endmodule
